// *** logic/tacc_cfg.svh ***
// Purpose: Constants for the temperature alarm configuration block
// Assumes: Temperatures are signed 13-bit words, 0.0625 degC per LSB
// Notes:   Register field positions and reset values live here
`ifndef TACC_CFG_SVH
`define TACC_CFG_SVH

// ****************************************************
// Configuration register fields
// ****************************************************
`define TACC_HYST_HI 10
`define TACC_HYST_LO 9
`define TACC_PDOWN_BIT 8
`define TACC_CLOCK_BIT 7
`define TACC_WLOCK_BIT 6
`define TACC_CLR_BIT 5
`define TACC_STS_BIT 4
`define TACC_OE_BIT 3
`define TACC_CRIT_BIT 2
`define TACC_POL_BIT 1
`define TACC_MODE_BIT 0
`define TACC_REG_RESET 16'h0000

// ****************************************************
// Hysteresis steps in temperature LSBs
// ****************************************************
`define TACC_TEMP_W 13
`define TACC_HYST_OFF 13'h0000
`define TACC_HYST_1P5 13'h0018
`define TACC_HYST_3P0 13'h0030
`define TACC_HYST_6P0 13'h0060

`endif

// *** logic/tacc_pkg.sv ***
// Purpose: Types of the temperature alarm configuration block
// Assumes: Constants come from tacc_cfg.svh
// Notes:   Nothing here is imported; users write tacc_pkg::name
package tacc_pkg;

   typedef enum logic [1:0] {
      TACC_HYST_NONE = 2'h0,
      TACC_HYST_SMALL = 2'h1,
      TACC_HYST_MID = 2'h2,
      TACC_HYST_LARGE = 2'h3
   } tacc_hyst_e;

   typedef struct packed {
      logic tripped;
   } tacc_cmp_s;

   typedef struct packed {
      tacc_hyst_e hysteresis_select;
      logic sensor_power_down;
      logic crit_limit_lock;
      logic window_limit_lock;
      logic alert_output_enable;
      logic crit_only_select;
      logic alert_polarity;
      logic alert_mode_select;
      logic alert_latched;
      logic cond_prev;
      logic [15:0] rdata;
   } tacc_state_s;

endpackage

// *** logic/tacc_trip_cmp.sv ***
// Purpose: One trip boundary with hysteresis on falling temperature
// Assumes: Temperature and boundary share one signed format
// Notes:   LOW_SIDE selects the lower window boundary behaviour
`timescale 1ns/10ps
`include "tacc_cfg.svh"

module tacc_trip_cmp #(
   parameter bit LOW_SIDE = 1'b0
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic update_in,
   input wire logic signed [`TACC_TEMP_W-1:0] temp_in,
   input wire logic signed [`TACC_TEMP_W-1:0] limit_in,
   input wire logic signed [`TACC_TEMP_W-1:0] hyst_in,
   output logic tripped_out
);

   tacc_pkg::tacc_cmp_s state;
   tacc_pkg::tacc_cmp_s next_state;
   logic signed [`TACC_TEMP_W:0] lower_edge;
   logic signed [`TACC_TEMP_W:0] temp_ext;

   // ****************************************************
   // Trip decision
   // ****************************************************
   always_comb begin
      next_state = state;
      // One extra bit so a low boundary minus hysteresis cannot wrap;
      // concatenations are unsigned, so both sides are cast back to signed
      temp_ext = $signed({temp_in[`TACC_TEMP_W-1], temp_in});
      lower_edge = $signed({limit_in[`TACC_TEMP_W-1], limit_in}) -
                   $signed({hyst_in[`TACC_TEMP_W-1], hyst_in});
      if (update_in) begin
         if (LOW_SIDE) begin
            // Trips below boundary minus hysteresis, clears at boundary
            if (temp_ext < lower_edge) begin
               next_state.tripped = 1'b1;
            end else if (temp_in >= limit_in) begin
               next_state.tripped = 1'b0;
            end
         end else begin
            if (temp_in > limit_in) begin
               next_state.tripped = 1'b1;
            end else if (temp_ext < lower_edge) begin
               next_state.tripped = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= '0;
      end else if (ce_in) begin
         state <= next_state;
      end
   end

   assign tripped_out = state.tripped;

endmodule

// *** logic/tacc_alarm_cfg.sv ***
// Purpose: Alarm configuration register and alert pin control
// Assumes: Register strobes and temperature come from logic on clk_in
// Notes:   rstn_in is the internal power-on reset; it alone clears locks
//
// Notes on behaviour
// - High flag holds until below limit minus hysteresis
// - Alert uses the same hysteresis
// - Any lock blocks hysteresis, shutdown, enable, polarity, mode
// - Bit 8 zero converts, one powers sensor down
// - Shutdown freezes data, no alerts, pin released
// - Bit 7 locks critical limit until power-on
// - Bit 6 locks window limits until power-on
// - Clear bit write-only, self-clearing, reads zero
// - Clear releases alert only in interrupt mode
// - Status bit shows alert actively asserted
// - Bit 3 enables alert output
// - Bit 2 restricts alert to critical alarm
// - Only window lock blocks critical-only select
// - Bit 1 sets alert polarity, low default
// - Bit 0 selects comparator or interrupt mode
// - Hysteresis 0, 1.5, 3, 6 degrees on fall
`timescale 1ns/10ps
`include "tacc_cfg.svh"

module tacc_alarm_cfg (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic cfg_wr_in,
   input wire logic [15:0] cfg_wdata_in,
   output logic [15:0] cfg_rdata_out,
   input wire logic temp_valid_in,
   input wire logic signed [`TACC_TEMP_W-1:0] temp_in,
   input wire logic signed [`TACC_TEMP_W-1:0] upper_limit_in,
   input wire logic signed [`TACC_TEMP_W-1:0] lower_limit_in,
   input wire logic signed [`TACC_TEMP_W-1:0] crit_limit_in,
   output logic conv_enable_out,
   output logic crit_wr_allow_out,
   output logic window_wr_allow_out,
   output logic crit_high_out,
   output logic alarm_high_out,
   output logic alarm_low_out,
   output logic alert_out,
   output logic alert_oe_out
);

   tacc_pkg::tacc_state_s state;
   tacc_pkg::tacc_state_s next_state;
   logic [2:0] tripped;
   logic signed [`TACC_TEMP_W-1:0] trip_limit [3];
   logic signed [`TACC_TEMP_W-1:0] hyst_amount;
   logic sample_update;
   logic any_lock;
   logic alarm_cond;
   logic alert_active;
   logic clear_req;

   // ****************************************************
   // Trip comparators: 0 upper, 1 lower, 2 critical
   // ****************************************************
   // Data stays frozen while powered down
   assign sample_update = temp_valid_in & ~state.sensor_power_down;

   // Steps are held in temperature LSBs so the compare needs no scaling
   always_comb begin
      case (state.hysteresis_select)
         tacc_pkg::TACC_HYST_NONE: hyst_amount = `TACC_HYST_OFF;
         tacc_pkg::TACC_HYST_SMALL: hyst_amount = `TACC_HYST_1P5;
         tacc_pkg::TACC_HYST_MID: hyst_amount = `TACC_HYST_3P0;
         tacc_pkg::TACC_HYST_LARGE: hyst_amount = `TACC_HYST_6P0;
         default: hyst_amount = `TACC_HYST_OFF;
      endcase
   end

   // Upper and critical trip on a rise; the lower boundary trips on a fall
   always_comb begin
      trip_limit[0] = upper_limit_in;
      trip_limit[1] = lower_limit_in;
      trip_limit[2] = crit_limit_in;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_trip
         tacc_trip_cmp #(
            .LOW_SIDE(gi == 1)
         ) u_trip (
            .clk_in(clk_in),
            .rstn_in(rstn_in),
            .ce_in(ce_in),
            .update_in(sample_update),
            .temp_in(temp_in),
            .limit_in(trip_limit[gi]),
            .hyst_in(hyst_amount),
            .tripped_out(tripped[gi])
         );
      end
   endgenerate

   // ****************************************************
   // Alarm condition and alert state
   // ****************************************************
   always_comb begin
      if (state.crit_only_select) begin
         alarm_cond = tripped[2];
      end else begin
         alarm_cond = |tripped;
      end
   end

   // ****************************************************
   // Write qualifiers
   // ****************************************************
   // Either lock freezes the alert configuration fields other than critical-only select
   assign any_lock = state.crit_limit_lock | state.window_limit_lock;
   // The clear is a one-cycle request; the bit itself is never stored
   assign clear_req = cfg_wr_in & cfg_wdata_in[`TACC_CLR_BIT];

   // Disabled or asleep, no alert may be raised, latched or not
   always_comb begin
      if (state.sensor_power_down || !state.alert_output_enable) begin
         alert_active = 1'b0;
      end else if (state.alert_mode_select) begin
         alert_active = state.alert_latched;
      end else begin
         alert_active = alarm_cond;
      end
   end

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      next_state = state;
      // Only the rising edge of the condition arms the interrupt latch, so
      // a standing alarm does not re-arm straight after the host clears it
      next_state.cond_prev = alarm_cond;
      if (cfg_wr_in) begin
         // Locks only ever set; the power-on reset is their sole clear
         if (cfg_wdata_in[`TACC_CLOCK_BIT]) begin
            next_state.crit_limit_lock = 1'b1;
         end
         if (cfg_wdata_in[`TACC_WLOCK_BIT]) begin
            next_state.window_limit_lock = 1'b1;
         end
         // Old lock values gate the fields, so a write that sets a lock
         // still updates the other fields of that same word
         if (!any_lock) begin
            next_state.hysteresis_select = tacc_pkg::tacc_hyst_e'(
               cfg_wdata_in[`TACC_HYST_HI:`TACC_HYST_LO]);
            next_state.sensor_power_down =
               cfg_wdata_in[`TACC_PDOWN_BIT];
            next_state.alert_output_enable =
               cfg_wdata_in[`TACC_OE_BIT];
            next_state.alert_polarity = cfg_wdata_in[`TACC_POL_BIT];
            next_state.alert_mode_select =
               cfg_wdata_in[`TACC_MODE_BIT];
         end
         if (!state.window_limit_lock) begin
            next_state.crit_only_select = cfg_wdata_in[`TACC_CRIT_BIT];
         end
      end
      // Clear acts only in interrupt mode; a new trip in the same cycle wins
      if (clear_req && state.alert_mode_select) begin
         next_state.alert_latched = 1'b0;
      end
      if (!state.alert_mode_select || state.sensor_power_down) begin
         next_state.alert_latched = 1'b0;
      end else if (alarm_cond && !state.cond_prev) begin
         next_state.alert_latched = 1'b1;
      end
      // Read image: clear bit always zero, reserved bits zero
      next_state.rdata = `TACC_REG_RESET;
      next_state.rdata[`TACC_HYST_HI:`TACC_HYST_LO] =
         next_state.hysteresis_select;
      next_state.rdata[`TACC_PDOWN_BIT] = next_state.sensor_power_down;
      next_state.rdata[`TACC_CLOCK_BIT] = next_state.crit_limit_lock;
      next_state.rdata[`TACC_WLOCK_BIT] = next_state.window_limit_lock;
      next_state.rdata[`TACC_CLR_BIT] = 1'b0;
      // Status follows the pin one cycle late
      next_state.rdata[`TACC_STS_BIT] = alert_active;
      next_state.rdata[`TACC_OE_BIT] = next_state.alert_output_enable;
      next_state.rdata[`TACC_CRIT_BIT] = next_state.crit_only_select;
      next_state.rdata[`TACC_POL_BIT] = next_state.alert_polarity;
      next_state.rdata[`TACC_MODE_BIT] = next_state.alert_mode_select;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= '0;
      end else if (ce_in) begin
         state <= next_state;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign cfg_rdata_out = state.rdata;
   assign conv_enable_out = ~state.sensor_power_down;
   // Permissions for the trip-limit registers held outside this block
   assign crit_wr_allow_out = ~state.crit_limit_lock;
   assign window_wr_allow_out = ~state.window_limit_lock;
   assign crit_high_out = tripped[2];
   assign alarm_high_out = tripped[0];
   assign alarm_low_out = tripped[1];

   // Active low is open drain and needs the pull-up; active high drives
   // both levels while enabled. Shutdown always releases the pin.
   always_comb begin
      if (state.sensor_power_down || !state.alert_output_enable) begin
         alert_out = 1'b0;
         alert_oe_out = 1'b0;
      end else if (state.alert_polarity) begin
         alert_out = alert_active;
         alert_oe_out = 1'b1;
      end else begin
         alert_out = 1'b0;
         alert_oe_out = alert_active;
      end
   end

endmodule

// *** test/tacc_alarm_cfg_props.sv ***
// Purpose: Assertions on the alarm configuration block ports
// Assumes: One clock domain, reset low clears all
// Notes:   Bound to every instance of the block
`timescale 1ns/10ps
module tacc_alarm_cfg_props (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic cfg_wr_in,
   input wire logic [15:0] cfg_wdata_in,
   input wire logic [15:0] cfg_rdata_out,
   input wire logic temp_valid_in,
   input wire logic signed [12:0] temp_in,
   input wire logic signed [12:0] upper_limit_in,
   input wire logic conv_enable_out,
   input wire logic crit_wr_allow_out,
   input wire logic window_wr_allow_out,
   input wire logic alarm_high_out,
   input wire logic alert_out,
   input wire logic alert_oe_out
);
   // ******
   // Properties
   // ******
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   wire tk = ce_in && cfg_wr_in;
   wire sm = ce_in && temp_valid_in && conv_enable_out;
   wire lk = cfg_rdata_out[7] || cfg_rdata_out[6];
   property p_rsvd;
      cfg_rdata_out[15:11] == 5'h00 && !cfg_rdata_out[5];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_pdown;
      tk && !lk && cfg_wdata_in[8] |=> !conv_enable_out;
   endproperty
   a_pdown: assert property (p_pdown) else $error("no power down");
   property p_sdrel; !conv_enable_out |-> !alert_oe_out; endproperty
   a_sdrel: assert property (p_sdrel) else $error("pin driven asleep");
   property p_clock;
      tk && cfg_wdata_in[7] || !crit_wr_allow_out |=> !crit_wr_allow_out;
   endproperty
   a_clock: assert property (p_clock) else $error("crit lock lost");
   property p_wlock;
      tk && cfg_wdata_in[6] || !window_wr_allow_out |=> !window_wr_allow_out;
   endproperty
   a_wlock: assert property (p_wlock) else $error("window lock lost");
   property p_blk;
      lk |=> $stable({cfg_rdata_out[10:8], cfg_rdata_out[3],
                      cfg_rdata_out[1:0]});
   endproperty
   a_blk: assert property (p_blk) else $error("locked field moved");
   property p_csel;
      cfg_rdata_out[6] |=> $stable(cfg_rdata_out[2]);
   endproperty
   a_csel: assert property (p_csel) else $error("crit select moved");
   property p_high;
      sm && temp_in > upper_limit_in |=> alarm_high_out;
   endproperty
   a_high: assert property (p_high) else $error("high flag missed");
   property p_sts;
      ce_in && alert_oe_out && alert_out == cfg_rdata_out[1]
         |=> cfg_rdata_out[4];
   endproperty
   a_sts: assert property (p_sts) else $error("status not shown");
   property p_cmp;
      sm && !cfg_wr_in && cfg_rdata_out[3:0] == 4'hA &&
         temp_in > upper_limit_in |=> alert_out && alert_oe_out;
   endproperty
   a_cmp: assert property (p_cmp) else $error("alert not tracking");
endmodule
bind tacc_alarm_cfg tacc_alarm_cfg_props u_props (.*);

// *** test/tacc_host_model.sv ***
// Purpose: Host side: register writes and the pulled-up alert line
// Assumes: Writes are one-cycle strobes on clk_in
// Notes:   Data lines show inverted data once a write is over
`timescale 1ns/10ps
module tacc_host_model (
   input wire logic clk_in,
   input wire logic alert_out,
   input wire logic alert_oe_out,
   output logic cfg_wr_out = 1'b0,
   output logic [15:0] cfg_wdata_out = 16'h0000,
   output logic alert_pin_out
);
   // ******
   // Pin and writes
   // ******
   // Released pin rests high through the pull-up
   assign alert_pin_out = alert_oe_out ? alert_out : 1'b1;
   task automatic write(input logic [15:0] d);
      @(negedge clk_in);
      cfg_wr_out = 1'b1;
      cfg_wdata_out = d;
      @(negedge clk_in);
      cfg_wr_out = 1'b0;
      cfg_wdata_out = ~d;
   endtask
endmodule

// *** test/tacc_alarm_cfg_tb.sv ***
// Purpose: Self-checking bench of the alarm configuration block
// Assumes: Host model makes the register writes
// Notes:   Driver queues expectations, a monitor compares them
`timescale 1ns/10ps
`include "tacc_cfg.svh"
`define CHK(n, g, e) n_tests++; if ((g) !== (e)) begin \
   fail_count++; $display("BAD %s %s exp %h got %h", cur, n, e, g); end
module tacc_alarm_cfg_tb;
   logic clk_in = 1'b0, rstn_in = 1'b0, ce_in = 1'b1;
   logic temp_valid_in = 1'b0, cfg_wr_in, pin;
   logic [15:0] cfg_wdata_in, cfg_rdata_out, hb;
   logic signed [12:0] temp_in = 13'sh0100, upper_limit_in = 13'sh0550;
   logic signed [12:0] lower_limit_in = -13'sh00A0, crit_limit_in = 13'sh0640;
   logic signed [12:0] st, hy [4];
   logic conv_enable_out, crit_wr_allow_out, window_wr_allow_out;
   logic crit_high_out, alarm_high_out, alarm_low_out, alert_out, alert_oe_out;
   logic [23:0] q [$];
   logic [23:0] e;
   int fail_count = 0, n_tests = 0, cyc = 0;
   string cur = "reset";
   event look;
   wire [23:0] obs = {cfg_rdata_out, conv_enable_out, crit_wr_allow_out,
      window_wr_allow_out, crit_high_out, alarm_high_out, alarm_low_out,
      pin, alert_oe_out};
   tacc_alarm_cfg u_dut (.*);
   tacc_host_model u_host (.clk_in, .alert_out, .alert_oe_out,
      .cfg_wr_out(cfg_wr_in), .cfg_wdata_out(cfg_wdata_in),
      .alert_pin_out(pin));
   initial forever #5 clk_in = ~clk_in;
   // ******
   // Driver tasks and monitor
   // ******
   task automatic exp(input logic [23:0] v);
      repeat (4) @(negedge clk_in);
      q.push_back(v);
      ->look;
   endtask
   task automatic wc(input logic [15:0] d, input logic [23:0] v);
      u_host.write(d);
      exp(v);
   endtask
   task automatic tc(input logic signed [12:0] t, input logic [23:0] v);
      @(negedge clk_in);
      temp_in = t;
      temp_valid_in = 1'b1;
      @(negedge clk_in);
      temp_valid_in = 1'b0;
      exp(v);
   endtask
   task automatic nxt(input string s);
      $display("test %s done", cur);
      cur = s;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(look) begin
      e = q.pop_front();
      `CHK("rdata", obs[23:8], e[23:8])
      `CHK("enables", obs[7:5], e[7:5])
      `CHK("flags", obs[4:2], e[4:2])
      `CHK("pin", obs[1:0], e[1:0])
   end
   // Whole run needs a few hundred cycles
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      hy = '{`TACC_HYST_OFF, `TACC_HYST_1P5, `TACC_HYST_3P0, `TACC_HYST_6P0};
      void'($urandom(32'hF60C));
      repeat (3) @(negedge clk_in);
      rstn_in = 1'b1;
      exp(24'h0000E2);
      nxt("hysteresis");
      for (int h = 0; h < 4; h++) begin
         hb = 16'(h) << 9;
         st = hy[h];
         wc(hb | 16'h003A, {hb | 16'h000A, 8'hE1});
         tc(upper_limit_in + 13'sh0001, {hb | 16'h001A, 8'hEB});
         tc(upper_limit_in - st, {hb | 16'h001A, 8'hEB});
         tc(upper_limit_in - st - 13'sh0001, {hb | 16'h000A, 8'hE1});
      end
      nxt("interrupt");
      wc(16'h0009, 24'h0009E2);
      tc(upper_limit_in + 13'sh0001, 24'h0019E9);
      tc(13'sh00C8 + 13'($urandom % 800), 24'h0019E1);
      wc(16'h0029, 24'h0009E2);
      wc(16'h0008, 24'h0008E2);
      tc(upper_limit_in + 13'sh0001, 24'h0018E9);
      wc(16'h0028, 24'h0018E9);
      nxt("critical");
      wc(16'h000E, 24'h000EE9);
      tc(crit_limit_in + 13'sh0001, 24'h001EFB);
      nxt("shutdown");
      wc(16'h010E, 24'h010E7A);
      tc(13'sh00C8 + 13'($urandom % 800), 24'h010E7A);
      wc(16'h000E, 24'h001EFB);
      tc(13'sh00C8 + 13'($urandom % 800), 24'h000EE1);
      nxt("window low");
      tc(lower_limit_in - 13'sh0001, 24'h000EE5);
      wc(16'h000A, 24'h001AE7);
      tc(lower_limit_in, 24'h000AE1);
      nxt("freeze");
      ce_in = 1'b0;
      wc(16'h0000, 24'h000AE1);
      ce_in = 1'b1;
      nxt("locks");
      wc(16'h008A, 24'h008AA1);
      wc(16'h0305, 24'h008EA1);
      wc(16'h0040, 24'h00CA81);
      wc(16'h0004, 24'h00CA81);
      @(negedge clk_in);
      rstn_in = 1'b0;
      repeat (3) @(negedge clk_in);
      rstn_in = 1'b1;
      exp(24'h0000E2);
      nxt("end");
      end_of_test();
   end
endmodule
